// *** rtl/serial_port_status_pkg.sv ***
// serial port status register: constants, field positions and carrier types
// assumes one 8-bit status word on a 32-bit bus slave and one link clock domain
package serial_port_status_pkg;

   // ************************************************
   // register map
   // ************************************************
   localparam logic [31:0] STATUS_OFF   = 32'h0000_0000;
   localparam logic [7:0]  STATUS_RESET = 8'h00;

   // field positions in the status word
   localparam int SAMPLE_POS = 7;
   localparam int EDGE_POS   = 6;
   localparam int DA_POS     = 5;
   localparam int STOP_POS   = 4;
   localparam int START_POS  = 3;
   localparam int RW_POS     = 2;
   localparam int UA_POS     = 1;
   localparam int BF_POS     = 0;

   // event indices of the link-to-bus toggle vector
   localparam int EV_START = 0;
   localparam int EV_STOP  = 1;
   localparam int EV_BYTE  = 2;
   localparam int EV_MATCH = 3;
   localparam int EV_NACK  = 4;
   localparam int EV_N     = 5;

   // ************************************************
   // types
   // ************************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;

   // one-cycle event strobes from the link-side serial engine
   typedef struct packed {
      logic start;        // start condition seen
      logic stop;         // stop condition seen
      logic byte_done;    // a byte moved on the bus
      logic byte_is_data; // that byte was data, not address
      logic addr_match;   // own address matched
      logic rw_bit;       // direction bit of the matched address
      logic nack;         // not-acknowledge seen
   } link_evt_type;

   // link-side configuration derived from the status register
   typedef struct packed {
      logic sample_at_end; // sample input at end of output time
      logic slew_ctrl_en;  // two-wire slew control active
      logic tx_on_falling; // transmit on falling serial clock edge
   } link_cfg_type;

endpackage

// *** rtl/serial_port_status_register.sv ***
// serial port status register with ahb-lite access and a link clock domain
// assumes the serial engine on link_clk gives one-cycle event strobes,
// and the mode bits come from the control registers on hclk
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// ************************************************
// two-flop synchroniser
// ************************************************
module status_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,   // destination clock
   input  wire logic             rst_n, // destination reset, active low
   input  wire logic [WIDTH-1:0] d,     // asynchronous input
   output logic      [WIDTH-1:0] q      // synchronised output
);
   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ************************************************
// top
// ************************************************
module serial_port_status_register
   import serial_port_status_pkg::*;
(
   input  wire logic         hclk,                // system clock
   input  wire logic         hresetn,             // async reset, active low
   input  wire logic         hsel,                // slave select
   input  wire logic [31:0]  haddr,               // byte address
   input  wire logic [1:0]   htrans,              // transfer type
   input  wire logic         hwrite,              // write when high
   input  wire logic [2:0]   hsize,               // transfer size
   input  wire logic         hready,              // bus ready
   input  wire logic [31:0]  hwdata,              // write data
   output logic      [31:0]  hrdata,              // read data
   output logic              hreadyout,           // slave ready
   output logic              hresp,               // response, always okay
   input  wire logic         i2c_mode,            // two-wire mode selected
   input  wire logic         spi_master,          // serial peripheral master
   input  wire logic         port_enable_bit,     // port enabled
   input  wire logic         clock_idle_polarity, // idle level of serial clock
   input  wire logic         buffer_full_flag,    // buffer holds a byte
   input  wire logic         address_update_flag, // address must be updated
   input  wire logic         link_clk,            // serial link clock
   input  wire link_evt_type link_evt,            // link event strobes
   output link_cfg_type      link_cfg             // link configuration
);

   // ************************************************
   // bus slave
   // ************************************************
   logic        wr_pend_r;
   logic        input_sample_phase_r;
   logic        edge_select_r;
   logic        da_r;
   logic        stop_r;
   logic        start_r;
   logic        rw_r;
   logic        acc;
   logic        hit;
   logic [7:0]  status;
   logic [7:0]  rd_val;

   assign acc       = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   assign hit       = (haddr[31:2] == STATUS_OFF[31:2]);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // live status word
   always_comb begin
      status             = STATUS_RESET;
      status[SAMPLE_POS] = input_sample_phase_r;
      status[EDGE_POS]   = edge_select_r;
      status[DA_POS]     = da_r;
      status[STOP_POS]   = stop_r;
      status[START_POS]  = start_r;
      status[RW_POS]     = rw_r;
      status[UA_POS]     = address_update_flag;
      status[BF_POS]     = buffer_full_flag;
   end

   // forward a write in its data phase to a read in the same cycle
   always_comb begin
      rd_val = status;
      if (wr_pend_r) begin
         rd_val[SAMPLE_POS] = hwdata[SAMPLE_POS];
         rd_val[EDGE_POS]   = hwdata[EDGE_POS];
      end
   end

   // address phase: note a pending write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
      end else begin
         wr_pend_r <= acc && hwrite && hit;
      end
   end

   // read data registered in the address phase, unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (acc && !hwrite) begin
         hrdata <= hit ? {24'h00_0000, rd_val} : 32'h0000_0000;
      end
   end

   // writable bits taken in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         input_sample_phase_r <= STATUS_RESET[SAMPLE_POS];
         edge_select_r        <= STATUS_RESET[EDGE_POS];
      end else if (wr_pend_r) begin
         input_sample_phase_r <= hwdata[SAMPLE_POS];
         edge_select_r        <= hwdata[EDGE_POS];
      end
   end

   // ************************************************
   // link domain reset and event capture
   // ************************************************
   logic             lrst_meta_r;
   logic             lrst_n_r;
   logic [EV_N-1:0]  ev_tog_r;
   logic             hold_data_r;
   logic             hold_rw_r;
   logic [EV_N-1:0]  ev_strobe;

   // reset asserts at once, releases on the link clock
   always_ff @(posedge link_clk or negedge hresetn) begin
      if (!hresetn) begin
         lrst_meta_r <= 1'b0;
         lrst_n_r    <= 1'b0;
      end else begin
         lrst_meta_r <= 1'b1;
         lrst_n_r    <= lrst_meta_r;
      end
   end

   always_comb begin
      ev_strobe           = '0;
      ev_strobe[EV_START] = link_evt.start;
      ev_strobe[EV_STOP]  = link_evt.stop;
      ev_strobe[EV_BYTE]  = link_evt.byte_done;
      ev_strobe[EV_MATCH] = link_evt.addr_match;
      ev_strobe[EV_NACK]  = link_evt.nack;
   end

   // each event flips its toggle
   always_ff @(posedge link_clk or negedge lrst_n_r) begin
      if (!lrst_n_r) begin
         ev_tog_r <= '0;
      end else begin
         ev_tog_r <= ev_tog_r ^ ev_strobe;
      end
   end

   // qualifiers held until the next event of their kind
   always_ff @(posedge link_clk or negedge lrst_n_r) begin
      if (!lrst_n_r) begin
         hold_data_r <= 1'b0;
         hold_rw_r   <= 1'b0;
      end else begin
         if (link_evt.byte_done) begin
            hold_data_r <= link_evt.byte_is_data;
         end
         if (link_evt.addr_match) begin
            hold_rw_r <= link_evt.rw_bit;
         end
      end
   end

   // ************************************************
   // event crossing into hclk
   // ************************************************
   logic [EV_N-1:0] ev_sync;
   logic [EV_N-1:0] ev_seen_r;
   logic [EV_N-1:0] ev_h;

   status_sync2 #(.WIDTH(EV_N)) u_ev_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     (ev_tog_r),
      .q     (ev_sync)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_seen_r <= '0;
      end else begin
         ev_seen_r <= ev_sync;
      end
   end

   assign ev_h = ev_sync ^ ev_seen_r;

   // ************************************************
   // bus condition flags
   // ************************************************
   // two-wire mode: last condition wins, stop over start in one cycle; disabled port holds both clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_r <= STATUS_RESET[START_POS];
         stop_r  <= STATUS_RESET[STOP_POS];
      end else if (!port_enable_bit) begin
         start_r <= 1'b0;
         stop_r  <= 1'b0;
      end else if (i2c_mode && ev_h[EV_STOP]) begin
         start_r <= 1'b0;
         stop_r  <= 1'b1;
      end else if (i2c_mode && ev_h[EV_START]) begin
         start_r <= 1'b1;
         stop_r  <= 1'b0;
      end
   end

   // data or address for the last byte
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         da_r <= STATUS_RESET[DA_POS];
      end else if (i2c_mode && ev_h[EV_BYTE]) begin
         da_r <= hold_data_r;
      end
   end

   // direction after an address match, dropped at start, stop or nack
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rw_r <= STATUS_RESET[RW_POS];
      end else if (i2c_mode && ev_h[EV_MATCH]) begin
         rw_r <= hold_rw_r;
      end else if (ev_h[EV_START] || ev_h[EV_STOP] || ev_h[EV_NACK]) begin
         rw_r <= 1'b0;
      end
   end

   // ************************************************
   // configuration into the link domain
   // ************************************************
   logic [4:0] cfg_sync;
   logic       smp_l;
   logic       cke_l;
   logic       ckp_l;
   logic       i2c_l;
   logic       mst_l;

   status_sync2 #(.WIDTH(5)) u_cfg_sync (
      .clk   (link_clk),
      .rst_n (lrst_n_r),
      .d     ({input_sample_phase_r, edge_select_r, clock_idle_polarity, i2c_mode, spi_master}),
      .q     (cfg_sync)
   );

   assign {smp_l, cke_l, ckp_l, i2c_l, mst_l} = cfg_sync;

   // phase and edge choice for the serial engine
   always_ff @(posedge link_clk or negedge lrst_n_r) begin
      if (!lrst_n_r) begin
         link_cfg <= '0;
      end else begin
         link_cfg.sample_at_end <= !i2c_l && mst_l && smp_l;
         link_cfg.slew_ctrl_en  <= i2c_l && !smp_l;
         link_cfg.tx_on_falling <= cke_l ^ ckp_l;
      end
   end

   // ************************************************
   // checks
   // ************************************************
   sequence s_start_ev;
      i2c_mode && port_enable_bit && ev_h[EV_START] && !ev_h[EV_STOP];
   endsequence

   sequence s_write_phase;
      acc && hwrite && hit ##1 wr_pend_r;
   endsequence

   property p_start_flag;
      @(posedge hclk) disable iff (!hresetn)
      s_start_ev |=> start_r && !stop_r;
   endproperty
   a_start_flag: assert property (p_start_flag) else $error("start flag not set");

   property p_stop_flag;
      @(posedge hclk) disable iff (!hresetn)
      i2c_mode && port_enable_bit && ev_h[EV_STOP] |=> stop_r && !start_r;
   endproperty
   a_stop_flag: assert property (p_stop_flag) else $error("stop flag not set");

   property p_disable_clear;
      @(posedge hclk) disable iff (!hresetn)
      !port_enable_bit [*2] |-> !start_r && !stop_r;
   endproperty
   a_disable_clear: assert property (p_disable_clear) else $error("flags kept while disabled");

   property p_da_flag;
      @(posedge hclk) disable iff (!hresetn)
      i2c_mode && ev_h[EV_BYTE] |=> da_r == $past(hold_data_r);
   endproperty
   a_da_flag: assert property (p_da_flag) else $error("data/address flag wrong");

   property p_rw_keep;
      @(posedge hclk) disable iff (!hresetn)
      i2c_mode && ev_h[EV_MATCH] |=> rw_r == $past(hold_rw_r);
   endproperty
   a_rw_keep: assert property (p_rw_keep) else $error("direction not captured");

   property p_rw_drop;
      @(posedge hclk) disable iff (!hresetn)
      !ev_h[EV_MATCH] && (ev_h[EV_NACK] || ev_h[EV_STOP]) |=> !rw_r;
   endproperty
   a_rw_drop: assert property (p_rw_drop) else $error("direction kept too long");

   property p_write_smp;
      @(posedge hclk) disable iff (!hresetn)
      s_write_phase |=> input_sample_phase_r == $past(hwdata[SAMPLE_POS]);
   endproperty
   a_write_smp: assert property (p_write_smp) else $error("sample phase not written");

   property p_sample_end;
      @(posedge link_clk) disable iff (!lrst_n_r)
      !i2c_l && mst_l && smp_l |=> link_cfg.sample_at_end;
   endproperty
   a_sample_end: assert property (p_sample_end) else $error("sampling phase wrong");

   property p_slew;
      @(posedge link_clk) disable iff (!lrst_n_r)
      i2c_l |=> link_cfg.slew_ctrl_en == !$past(smp_l);
   endproperty
   a_slew: assert property (p_slew) else $error("slew control wrong");

   property p_edge_low;
      @(posedge link_clk) disable iff (!lrst_n_r)
      !ckp_l |=> link_cfg.tx_on_falling == $past(cke_l);
   endproperty
   a_edge_low: assert property (p_edge_low) else $error("edge wrong, idle low");

   property p_edge_high;
      @(posedge link_clk) disable iff (!lrst_n_r)
      ckp_l |=> link_cfg.tx_on_falling == !$past(cke_l);
   endproperty
   a_edge_high: assert property (p_edge_high) else $error("edge wrong, idle high");

endmodule

`default_nettype wire

// *** verification/link_event_model.sv ***
// model of the serial engine that sits on the link side of the status register
// assumes a free-running link clock; events are one-cycle strobes on that clock
`timescale 1ns/1ps
`default_nettype none

// ************************************************
// link event source
// ************************************************
module link_event_model
   import serial_port_status_pkg::*;
(
   input  wire logic link_clk, // serial link clock
   output link_evt_type link_evt // event strobes towards the register
);

   // all strobes idle until a scenario fires one
   initial link_evt = '0;

   // one strobe for one link cycle, then a quiet gap long enough for the crossing
   task automatic fire(input logic [6:0] v);
      @(posedge link_clk);
      link_evt <= link_evt_type'(v);
      @(posedge link_clk);
      link_evt <= '0;
      repeat (6) @(posedge link_clk);
   endtask

endmodule
`default_nettype wire

// *** verification/serial_port_status_register_tb.sv ***
// self-checking bench for the serial port status register
// assumes an ahb-lite master in this module and the link event model as far side
`timescale 1ns/1ps
`default_nettype none

// ************************************************
// bench top
// ************************************************
module serial_port_status_register_tb;
   import serial_port_status_pkg::*;

   logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0]  haddr, hwdata, hrdata, rv;
   logic [1:0]   htrans;
   logic [2:0]   hsize;
   logic         i2c_mode, spi_master, port_enable_bit, clock_idle_polarity;
   logic         buffer_full_flag, address_update_flag, link_clk;
   link_evt_type link_evt;
   link_cfg_type link_cfg;
   int           n_errors, n_tests;

   // clocks: link clock offset in phase from the bus clock
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #32 link_clk = ~link_clk;
   end

   serial_port_status_register dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .i2c_mode(i2c_mode), .spi_master(spi_master),
      .port_enable_bit(port_enable_bit), .clock_idle_polarity(clock_idle_polarity),
      .buffer_full_flag(buffer_full_flag), .address_update_flag(address_update_flag),
      .link_clk(link_clk), .link_evt(link_evt), .link_cfg(link_cfg));

   link_event_model far (.link_clk(link_clk), .link_evt(link_evt));

   // ************************************************
   // bus and compare tasks
   // ************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one single-word transfer; address phase held until ready, then data phase
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= HTRANS_NONSEQ;
      haddr  <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask

   task automatic rd(input logic [31:0] a);
      xfer(1'b0, a, 32'h0000_0000);
   endtask

   // mode and live status levels, msb first: two-wire, master, enable, idle polarity, buffer full, address update
   task automatic drive(input logic [5:0] m);
      {i2c_mode, spi_master, port_enable_bit, clock_idle_polarity, buffer_full_flag, address_update_flag} <= m;
   endtask

   task automatic settle();
      repeat (8) @(posedge link_clk);
      @(posedge hclk);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   // reset value, live bits and read-only fields
   task automatic t_regs();
      rd(32'h0000_0000);
      check(rv, 32'h0000_0000);
      check({31'h0, hresp}, 32'h0000_0000);
      drive(6'h03);
      rd(32'h0000_0000);
      check(rv, 32'h0000_0003);
      drive(6'h00);
      xfer(1'b1, 32'h0000_0000, 32'hffff_ffff);
      rd(32'h0000_0000);
      check(rv, 32'h0000_00c0);
      xfer(1'b1, 32'h0000_0004, 32'h0000_0000);
      rd(32'h0000_0000);
      check(rv, 32'h0000_00c0);
      rd(32'h0000_0004);
      check(rv, 32'h0000_0000);
      // a write without slave select must not land
      hsel <= 1'b0;
      xfer(1'b1, 32'h0000_0000, 32'h0000_0000);
      hsel <= 1'b1;
      rd(32'h0000_0000);
      check(rv, 32'h0000_00c0);
   endtask

   // sampling phase, slew control and transmit edge on the link config
   task automatic t_cfg();
      drive(6'h10);
      xfer(1'b1, 32'h0000_0000, 32'h0000_0080);
      settle();
      check({29'h0, link_cfg}, 32'h0000_0004);
      xfer(1'b1, 32'h0000_0000, 32'h0000_0000);
      settle();
      check({29'h0, link_cfg}, 32'h0000_0000);
      drive(6'h20);
      settle();
      check({29'h0, link_cfg}, 32'h0000_0002);
      xfer(1'b1, 32'h0000_0000, 32'h0000_0080);
      settle();
      check({29'h0, link_cfg}, 32'h0000_0000);
      drive(6'h00);
      // every pairing of idle polarity and edge select
      for (int k = 0; k < 4; k++) begin
         drive({3'h0, k[1], 2'h0});
         xfer(1'b1, 32'h0000_0000, {25'h0, k[0], 6'h00});
         settle();
         check({29'h0, link_cfg}, {31'h0, k[0] ^ k[1]});
      end
      drive(6'h00);
      xfer(1'b1, 32'h0000_0000, 32'h0000_0000);
   endtask

   // bus conditions, byte kind and direction flags in two-wire mode
   task automatic t_events();
      drive(6'h28);
      far.fire(7'h40);
      rd(32'h0000_0000);
      check(rv, 32'h0000_0008);
      far.fire(7'h20);
      rd(32'h0000_0000);
      check(rv, 32'h0000_0010);
      far.fire(7'h40);
      drive(6'h20);
      settle();
      rd(32'h0000_0000);
      check(rv, 32'h0000_0000);
      drive(6'h28);
      far.fire(7'h18);
      rd(32'h0000_0000);
      check(rv, 32'h0000_0020);
      far.fire(7'h10);
      rd(32'h0000_0000);
      check(rv, 32'h0000_0000);
      far.fire(7'h06);
      rd(32'h0000_0000);
      check(rv, 32'h0000_0004);
      far.fire(7'h01);
      rd(32'h0000_0000);
      check(rv, 32'h0000_0000);
      far.fire(7'h06);
      far.fire(7'h40);
      rd(32'h0000_0000);
      check(rv, 32'h0000_0008);
      // outside two-wire mode a stop must leave the start and stop flags alone
      drive(6'h08);
      settle();
      far.fire(7'h20);
      rd(32'h0000_0000);
      check(rv, 32'h0000_0008);
   endtask

   // reset in mid-run returns the stored bits and the link config to zero
   task automatic t_reset();
      xfer(1'b1, 32'h0000_0000, 32'h0000_00c0);
      settle();
      check({29'h0, link_cfg}, 32'h0000_0001);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      settle();
      rd(32'h0000_0000);
      check(rv, 32'h0000_0000);
      check({29'h0, link_cfg}, 32'h0000_0000);
   endtask

   // ************************************************
   // main sequence and watchdog
   // ************************************************
   initial begin
      n_errors = 0;
      n_tests = 0;
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      drive(6'h00);
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      settle();
      t_regs();
      t_cfg();
      t_events();
      t_reset();
      results();
   end

   // cuts a hang short well past the expected run length
   initial begin
      repeat (40000) @(posedge hclk);
      n_errors++;
      results();
   end

endmodule
`default_nettype wire
